// >>> rtl/css_defs.vh
// css_defs.vh - constants of the codec start-up sequencer: register indices,
// field positions, reset values and timing figures.
// assumes: included by bare name from rtl/css_startup_seq.v only.
`ifndef CSS_DEFS_VH
`define CSS_DEFS_VH
// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define CSS_R_STATUS     5'd0
`define CSS_R_INSEL      5'd2
`define CSS_R_GAIN_LO    5'd3
`define CSS_R_GAIN_HI    5'd10
`define CSS_R_MIX_A      5'd13
`define CSS_R_MIX_B      5'd14
`define CSS_R_CLKASSIGN  5'd15
`define CSS_R_CLKGEN_LO  5'd16
`define CSS_R_CLKGEN_HI  5'd24
`define CSS_R_FILTER     5'd25
`define CSS_R_SERIAL     5'd26
`define CSS_R_ENABLE     5'd27
`define CSS_R_POWER      5'd28
`define CSS_R_LAST       5'd28
// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CSS_ST_CLKRDY    15
`define CSS_ST_PDNSTATE  14
`define CSS_ST_PB1       3
`define CSS_ST_PB2       2
`define CSS_ST_LVALID    1
`define CSS_ST_RVALID    0
`define CSS_PW_PDNREQ    15
`define CSS_PW_AUTOCAL   14
`define CSS_PW_CGEN_HI   13
`define CSS_PW_CGEN_LO   11
`define CSS_PW_CONV_HI   10
`define CSS_PW_CONV_LO   8
`define CSS_PW_BCLK_HI   7
`define CSS_PW_BCLK_LO   5
`define CSS_SR_SLOT      6
`define CSS_SR_SLOTAUX   5
`define CSS_SR_CAPLOCK   4
`define CSS_EN_MIX_D2D1  4
`define CSS_EN_MIX_AD    5
// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define CSS_RST_POWER    16'h8000
`define CSS_RST_ZERO     16'h0000
`define CSS_GAIN_MUTE    16'hFFFF
// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CSS_CLK_MHZ      250
`define CSS_T_SETTLE_US  400
`define CSS_T_WAKE_MS    470
`define CSS_T_CAL_MS     4
`define CSS_FS_DELAY     3'd6
`endif

// >>> rtl/css_startup_seq.v
// css_startup_seq.v - start-up and power-state sequencer of a serial audio
// codec, with its control registers behind an AXI4-Lite slave.
// assumes: aclk 250 MHz, pins asynchronous to aclk, one AXI master.
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
`include "css_defs.vh"

module css_startup_seq #(
    parameter SETTLE_CYC = `CSS_T_SETTLE_US * `CSS_CLK_MHZ,
    parameter WAKE_CYC   = `CSS_T_WAKE_MS * `CSS_CLK_MHZ * 1000,
    parameter CAL_CYC    = `CSS_T_CAL_MS * `CSS_CLK_MHZ * 1000
) (
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite write address / data / response
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // pins
    input  wire        frame_sync,
    input  wire [2:0]  conv_clk_pin,
    input  wire        hw_sleep_pin,
    input  wire        bus_role_strap,
    // control outputs
    output reg  [2:0]  clk_gen_enable,
    output reg  [2:0]  conversion_clk_outputs_enable,
    output reg  [2:0]  bit_clk_outputs_enable,
    output reg  [3:0]  converter_running,
    output reg  [1:0]  mix_active,
    output reg         conversion_powerdown_state
);
    // ------------------------------------------------------------------------
    // pin synchronisers: three stages, level moves once stages 2 and 3 agree
    // ------------------------------------------------------------------------
    reg  [5:0] sy1_r;                 // first stage, read only by sy2_r
    reg  [5:0] sy2_r;
    reg  [5:0] sy3_r;
    reg  [5:0] lvl_r;                 // filtered levels
    reg  [5:0] lvl_d_r;               // previous filtered levels
    wire [5:0] pins = {bus_role_strap, hw_sleep_pin, conv_clk_pin, frame_sync};
    wire [5:0] rise = lvl_r & ~lvl_d_r;
    wire       fs_edge  = rise[0];
    wire [2:0] cc_edge  = rise[3:1];
    wire       sleep_lv = lvl_r[4];

    // sampling and filtering of all pins; keeps running through reset so
    // the strap level is already filtered when reset captures it
    always @(posedge aclk) begin
        sy1_r   <= pins;
        sy2_r   <= sy1_r;
        sy3_r   <= sy2_r;
        lvl_r   <= (sy2_r & sy3_r) | (lvl_r & (sy2_r ^ sy3_r));
        lvl_d_r <= lvl_r;
    end

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    // picks one conversion clock edge by a two-bit assignment code
    function pick_edge(input [2:0] e, input [1:0] s);
        case (s)
            2'd0:    pick_edge = e[0];
            2'd1:    pick_edge = e[1];
            default: pick_edge = e[2];
        endcase
    endfunction

    // merges a 16-bit write under byte strobes
    function [15:0] merge(input [15:0] old, input [15:0] d, input [1:0] st);
        merge = {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
    endfunction

    // ------------------------------------------------------------------------
    // clock settling and power state
    // ------------------------------------------------------------------------
    localparam PS_DOWN = 2'd0;        // fully powered down
    localparam PS_WAKE = 2'd1;        // ramping to standby
    localparam PS_CAL  = 2'd2;        // autocalibration
    localparam PS_UP   = 2'd3;        // out of power-down

    reg  [1:0]  ps_r;
    reg  [26:0] ps_cnt_r;             // wake / cal counter
    reg  [16:0] settle_r;             // clock settle counter
    reg         clk_ready_r;
    reg         role_master_r;        // strap caught while reset is held
    reg         cal_need_r;           // calibration owed since hw reset/sleep
    reg  [15:0] regs_r [0:31];        // control register storage
    wire        pdn_req  = regs_r[`CSS_R_POWER][`CSS_PW_PDNREQ];
    wire        force_cal = regs_r[`CSS_R_POWER][`CSS_PW_AUTOCAL];
    wire        pwr_up    = (ps_r == PS_UP);

    // settle counter, strap capture and power state machine
    always @(posedge aclk) begin
        if (!aresetn) begin
            settle_r      <= 17'd0;
            clk_ready_r   <= 1'b0;
            role_master_r <= lvl_r[5];            // strap held through reset
            ps_r          <= PS_DOWN;
            ps_cnt_r      <= 27'd0;
            cal_need_r    <= 1'b1;                // hw reset owes a cal
        end else begin
            // internal clocks count as stable after the settle time
            if (!clk_ready_r) begin
                settle_r <= settle_r + 17'd1;
                if (settle_r >= SETTLE_CYC[16:0] - 17'd1)
                    clk_ready_r <= 1'b1;
            end
            if (sleep_lv) begin
                // sleep pin: drop to power-down, cal owed on release
                ps_r       <= PS_DOWN;
                cal_need_r <= 1'b1;
            end else begin
                case (ps_r)
                    PS_DOWN: begin
                        // leave only once the request bit is cleared
                        if (!pdn_req && clk_ready_r) begin
                            ps_r     <= PS_WAKE;
                            ps_cnt_r <= 27'd0;
                        end
                    end
                    PS_WAKE: begin
                        ps_cnt_r <= ps_cnt_r + 27'd1;
                        if (pdn_req)
                            ps_r <= PS_DOWN;
                        else if (ps_cnt_r >= WAKE_CYC[26:0] - 27'd1) begin
                            ps_cnt_r <= 27'd0;
                            // skip cal after software power-down unless autocal is set
                            ps_r <= (cal_need_r || force_cal) ? PS_CAL : PS_UP;
                        end
                    end
                    PS_CAL: begin
                        ps_cnt_r <= ps_cnt_r + 27'd1;
                        if (pdn_req)
                            ps_r <= PS_DOWN;
                        else if (ps_cnt_r >= CAL_CYC[26:0] - 27'd1) begin
                            ps_r       <= PS_UP;
                            cal_need_r <= 1'b0;
                        end
                    end
                    default: begin
                        if (pdn_req)
                            ps_r <= PS_DOWN;              // software power-down
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // axi4-lite slave and register file
    // ------------------------------------------------------------------------
    reg        aw_held_r;
    reg        w_held_r;
    reg  [7:0] aw_addr_r;
    reg [15:0] w_data_r;
    reg  [1:0] w_strb_r;
    reg  [3:0] pb_r;                  // {cap r, cap l, pb2, pb1}
    wire [7:0] wa   = aw_held_r ? aw_addr_r : s_axi_awaddr;
    wire [15:0] wd  = w_held_r ? w_data_r : s_axi_wdata[15:0];
    wire [1:0] ws   = w_held_r ? w_strb_r : s_axi_wstrb[1:0];
    wire       aw_ok = aw_held_r | (s_axi_awvalid & s_axi_awready);
    wire       w_ok  = w_held_r | (s_axi_wvalid & s_axi_wready);
    wire       do_wr = aw_ok & w_ok & ~s_axi_bvalid;
    wire [4:0] widx  = wa[6:2];
    wire       wmap  = ~wa[7] && (widx <= `CSS_R_LAST);
    // writes to clock generator, serial and power registers are dropped until clocks are ready
    wire       wlock = !clk_ready_r && (((widx >= `CSS_R_CLKGEN_LO) &&
                       (widx <= `CSS_R_CLKGEN_HI)) || (widx == `CSS_R_SERIAL) ||
                       (widx == `CSS_R_POWER));
    // enable register ignored while powered down
    wire       wdrop = wlock || (widx == `CSS_R_ENABLE && !pwr_up);
    wire [4:0] ridx  = s_axi_araddr[6:2];
    wire       rmap  = ~s_axi_araddr[7] && (ridx <= `CSS_R_LAST);
    wire [15:0] status = {clk_ready_r & role_master_r, pwr_up,
                          10'h000, pb_r[0], pb_r[1], pb_r[2], pb_r[3]};
    wire [5:0] en    = regs_r[`CSS_R_ENABLE][5:0];
    integer    i;

    // write and read channels; stored values read back on the next access
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= 2'b00;
            s_axi_rdata   <= 32'h0000_0000;
            aw_held_r     <= 1'b0;
            w_held_r      <= 1'b0;
            aw_addr_r     <= 8'h00;
            w_data_r      <= 16'h0000;
            w_strb_r      <= 2'b00;
            for (i = 0; i < 32; i = i + 1)
                regs_r[i] <= `CSS_RST_ZERO;
            regs_r[`CSS_R_POWER] <= `CSS_RST_POWER;
            for (i = 3; i <= 10; i = i + 1)
                regs_r[i] <= `CSS_GAIN_MUTE;
        end else begin
            // hold whichever half arrives first
            if (s_axi_awvalid && s_axi_awready && !do_wr) begin
                aw_held_r     <= 1'b1;
                aw_addr_r     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready && !do_wr) begin
                w_held_r     <= 1'b1;
                w_data_r     <= s_axi_wdata[15:0];
                w_strb_r     <= s_axi_wstrb[1:0];
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                aw_held_r     <= 1'b0;
                w_held_r      <= 1'b0;
                s_axi_awready <= 1'b0;
                s_axi_wready  <= 1'b0;
                s_axi_bvalid  <= 1'b1;
                s_axi_bresp   <= wmap ? 2'b00 : 2'b10;
                // dropped writes still answer okay, store nothing
                if (wmap && !wdrop && widx != `CSS_R_STATUS)
                    regs_r[widx] <= merge(regs_r[widx], wd, ws);
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            // read
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= rmap ? 2'b00 : 2'b10;
                s_axi_rdata   <= !rmap ? 32'h0000_0000 :
                                 (ridx == `CSS_R_STATUS) ? {16'h0000, status} :
                                 {16'h0000, regs_r[ridx]};
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
            // forced defaults while powered down, last assignment wins
            if (!pwr_up) begin
                regs_r[`CSS_R_INSEL]     <= `CSS_RST_ZERO;
                regs_r[`CSS_R_MIX_A]     <= `CSS_RST_ZERO;
                regs_r[`CSS_R_MIX_B]     <= `CSS_RST_ZERO;
                regs_r[`CSS_R_CLKASSIGN] <= `CSS_RST_ZERO;
                regs_r[`CSS_R_FILTER]    <= `CSS_RST_ZERO;
                regs_r[`CSS_R_ENABLE]    <= `CSS_RST_ZERO;
            end
            // gains held muted unless their dac runs
            for (i = 3; i <= 6; i = i + 1)
                if (!converter_running[0])
                    regs_r[i] <= `CSS_GAIN_MUTE;
            for (i = 7; i <= 10; i = i + 1)
                if (!converter_running[1])
                    regs_r[i] <= `CSS_GAIN_MUTE;
        end
    end

    // ------------------------------------------------------------------------
    // conversion start: resources 0 dac1, 1 dac2, 2 adc left, 3 adc right
    // ------------------------------------------------------------------------
    reg  [11:0] fs_cnt_r;             // frame edges since enable, 3 bits each
    reg  [1:0]  pend_r;               // adc sample taken this frame
    reg  [3:0]  armed;                // six frame edges seen
    reg  [3:0]  cc_sel;               // assigned conversion clock edge
    wire [15:0] asg  = regs_r[`CSS_R_CLKASSIGN];
    wire        lock = regs_r[`CSS_R_SERIAL][`CSS_SR_CAPLOCK];
    integer     ci;                   // loop index of the arming logic
    integer     fi;                   // loop index of the start sequence

    // arming and clock selection per resource; both adcs share one clock
    always @* begin
        armed  = 4'h0;
        cc_sel = 4'h0;
        for (ci = 0; ci < 4; ci = ci + 1)
            armed[ci] = (fs_cnt_r[3*ci +: 3] == `CSS_FS_DELAY);
        cc_sel[0] = pick_edge(cc_edge, asg[1:0]);
        cc_sel[1] = pick_edge(cc_edge, asg[3:2]);
        cc_sel[2] = pick_edge(cc_edge, asg[5:4]);
        cc_sel[3] = pick_edge(cc_edge, asg[5:4]);
    end

    // per-resource start sequence, status flags and outputs
    always @(posedge aclk) begin
        if (!aresetn) begin
            fs_cnt_r                      <= 12'h000;
            pend_r                        <= 2'b00;
            pb_r                          <= 4'h0;
            converter_running             <= 4'h0;
            mix_active                    <= 2'b00;
            clk_gen_enable                <= 3'b000;
            conversion_clk_outputs_enable <= 3'b000;
            bit_clk_outputs_enable        <= 3'b000;
            conversion_powerdown_state    <= 1'b1;
        end else begin
            for (fi = 0; fi < 4; fi = fi + 1) begin
                if (!en[fi] || !pwr_up) begin
                    fs_cnt_r[3*fi +: 3]   <= 3'd0;
                    converter_running[fi] <= 1'b0;
                end else begin
                    if (fs_edge && !armed[fi])
                        fs_cnt_r[3*fi +: 3] <= fs_cnt_r[3*fi +: 3] + 3'd1;
                    // first assigned clock edge after sixth frame edge
                    if (armed[fi] && cc_sel[fi])
                        converter_running[fi] <= 1'b1;
                end
            end
            // playback request from the next frame after enable
            pb_r[0] <= en[0] & pwr_up & (pb_r[0] | fs_edge);
            pb_r[1] <= en[1] & pwr_up & (pb_r[1] | fs_edge);
            // adc sample pending; a new sample wins over the frame clear
            pend_r <= (pend_r & {2{~fs_edge}}) | (converter_running[3:2] & cc_sel[3:2]);
            if (fs_edge) begin
                // valid flags per frame; lock aligns both channels
                pb_r[2] <= lock ? (pend_r[0] & pend_r[1]) : pend_r[0];
                pb_r[3] <= lock ? (pend_r[0] & pend_r[1]) : pend_r[1];
            end
            // mixes follow their enable bits at once
            mix_active <= {en[`CSS_EN_MIX_AD], en[`CSS_EN_MIX_D2D1]} & {2{pwr_up}};
            // generator and pin enables from the power register
            clk_gen_enable <= regs_r[`CSS_R_POWER][`CSS_PW_CGEN_HI:`CSS_PW_CGEN_LO];
            conversion_clk_outputs_enable <=
                regs_r[`CSS_R_POWER][`CSS_PW_CONV_HI:`CSS_PW_CONV_LO];
            bit_clk_outputs_enable <= regs_r[`CSS_R_POWER][`CSS_PW_BCLK_HI:`CSS_PW_BCLK_LO];
            conversion_powerdown_state <= ~pwr_up;
        end
    end

endmodule // css_startup_seq

// >>> sim/css_seq_checker.sv
// css_seq_checker.sv - concurrent checks on the ports of css_startup_seq.
// assumes: one aclk domain, aresetn synchronous and active low.
`timescale 1ns/10ps
module css_seq_checker #(
    parameter WAKE_CYC = 200
) (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // write channels
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    // read channels
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    // control outputs
    input wire logic [3:0]  converter_running,
    input wire logic [1:0]  mix_active,
    input wire logic        conversion_powerdown_state
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // run length of the powered-down flag; 2-state so it starts clean
    int unsigned hi_r = 0;
    always @(posedge aclk) hi_r <= conversion_powerdown_state ? hi_r + 1 : 0;
    // address and data taken together
    wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire rd_go = s_axi_arvalid && s_axi_arready;
    property p_bans; wr_go |=> s_axi_bvalid; endproperty
    a_bans: assert property (p_bans) else $error("write left unanswered");
    property p_bslv; wr_go && s_axi_awaddr[7] |=> s_axi_bresp == 2'h2; endproperty
    a_bslv: assert property (p_bslv) else $error("unmapped write not refused");
    property p_rans; rd_go |=> s_axi_rvalid; endproperty
    a_rans: assert property (p_rans) else $error("read left unanswered");
    property p_unmap; rd_go && s_axi_araddr[7] |=> s_axi_rresp == 2'h2
        && s_axi_rdata == 0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
    property p_rst; disable iff (1'b0) !aresetn |=> conversion_powerdown_state
        && converter_running == 4'h0 && mix_active == 2'h0; endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_down; $rose(conversion_powerdown_state) |=> converter_running == 4'h0
        && mix_active == 2'h0; endproperty
    a_down: assert property (p_down) else $error("resources kept past power-down");
    property p_run; $rose(converter_running[0]) |-> !conversion_powerdown_state; endproperty
    a_run: assert property (p_run) else $error("dac started while down");
    property p_mix; $rose(mix_active[0]) |-> !conversion_powerdown_state; endproperty
    a_mix: assert property (p_mix) else $error("mix started while down");
    property p_wake; $fell(conversion_powerdown_state) |-> hi_r >= WAKE_CYC; endproperty
    a_wake: assert property (p_wake) else $error("standby reached too early");
    c_wake: cover property ($fell(conversion_powerdown_state));
    c_run: cover property (converter_running == 4'hF);
    c_mix: cover property (mix_active == 2'h3);
endmodule // css_seq_checker

bind css_startup_seq css_seq_checker #(.WAKE_CYC(WAKE_CYC)) i_css_seq_checker (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .converter_running(converter_running),
    .mix_active(mix_active), .conversion_powerdown_state(conversion_powerdown_state));

// >>> sim/css_link_model.sv
// css_link_model.sv - pin-side partner: frame sync, conversion clocks, strap.
// assumes: run comes from the bench; link timing unrelated to aclk.
`timescale 1ns/10ps
module css_link_model (
    // frame control
    input  wire logic  run,
    // pins into the sequencer
    output logic       frame_sync = 1'b0,
    output logic [2:0] conv_clk_pin = 3'h0,
    output logic       bus_role_strap
);
    // ------------------------------------------------------------
    // 32 ns link timebase, offset so it never lines up with aclk
    // ------------------------------------------------------------
    logic       lclk = 1'b0; // link timebase
    logic [2:0] k = 3'h0;    // slot position in a frame
    initial #3 forever #16 lclk = ~lclk;
    // master level held from power-up, so valid while reset is low
    assign bus_role_strap = 1'b1;
    // frame pulse every 8 slots; pins stand still while frames are off
    always @(posedge lclk) begin
        k <= run ? k + 3'h1 : 3'h0;
        frame_sync <= run && k == 3'h0;
        conv_clk_pin <= run ? {3{k[1]}} : 3'h0;
    end
endmodule // css_link_model

// >>> sim/tb.sv
// tb.sv - self-checking bench of css_startup_seq over AXI4-Lite.
// assumes: checker bound from its own file; link model drives all pins but the sleep pin.
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
$display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module tb;
    // ------------------------------------------------------------
    // signals; long counts shortened so the run stays brief
    // ------------------------------------------------------------
    localparam SETTLE = 50, WAKE = 200, CAL = 30;
    logic        aclk = 1'b0, aresetn = 1'b0, run = 1'b0, sleep = 1'b0;
    logic [7:0]  awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0000_0000, rdat, got;
    logic        awv = 1'b0, wv = 1'b0, arv = 1'b0, awr, wr_, bv, arr, rv, fs, strap, pdn;
    logic [1:0]  bresp, rresp, mix, gresp;
    logic [2:0]  cclk, cge, cco, bco;
    logic [3:0]  runs;
    int          failures = 0, total_checks = 0, fcnt = 0;
    always #2 aclk = ~aclk;
    always @(posedge fs) fcnt++;
    css_startup_seq #(.SETTLE_CYC(SETTLE), .WAKE_CYC(WAKE), .CAL_CYC(CAL)) i_css_startup_seq (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wr_), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(1'b1), .frame_sync(fs),
        .conv_clk_pin(cclk), .hw_sleep_pin(sleep), .bus_role_strap(strap),
        .clk_gen_enable(cge), .conversion_clk_outputs_enable(cco),
        .bit_clk_outputs_enable(bco), .converter_running(runs), .mix_active(mix),
        .conversion_powerdown_state(pdn));
    css_link_model i_css_link_model (.run(run), .frame_sync(fs), .conv_clk_pin(cclk),
        .bus_role_strap(strap));
    // ------------------------------------------------------------
    // bus tasks; ready lines stay high so no answer is ever stalled
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        awa <= a;
        wd <= {16'h0000, d};
        awv <= 1'b1;
        wv <= 1'b1;
        do begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wr_) wv <= 1'b0;
        end while (bv !== 1'b1);
        gresp = bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        ara <= a;
        arv <= 1'b1;
        do begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        got = rdat;
        gresp = rresp;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        rd(a);
        `CHK(got, {16'h0000, e})
    endtask
    // cycles until conversion resources leave power-down
    task automatic wait_up(output int n);
        n = 0;
        while (pdn !== 1'b0) begin
            @(posedge aclk);
            n++;
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ------------------------------------------------------------
    // start-up sequence, then power-down and recovery paths
    // ------------------------------------------------------------
    initial begin
        int n;
        int f0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rchk(8'h00, 16'h0000);
        rchk(8'h70, 16'h8000);
        rchk(8'h0C, 16'hFFFF);
        wr(8'h68, 16'h0070);
        rchk(8'h68, 16'h0000);
        wr(8'h80, 16'h1234);
        `CHK(gresp, 2'h2)
        rd(8'h80);
        `CHK(gresp, 2'h2)
        do rd(8'h00); while (got[15] !== 1'b1);
        wr(8'h68, 16'h0070);
        rchk(8'h68, 16'h0070);
        wr(8'h6C, 16'h003F);
        rchk(8'h6C, 16'h0000);
        wr(8'h08, 16'h0005);
        rchk(8'h08, 16'h0000);
        wr(8'h70, 16'h3FE0);
        repeat (2) @(posedge aclk);
        `CHK({cge, cco, bco}, 9'h1FF)
        wait_up(n);
        `CHK(n > WAKE + CAL / 2, 1'b1)
        rchk(8'h00, 16'hC000);
        wr(8'h64, 16'h0001);
        rchk(8'h64, 16'h0001);
        wr(8'h0C, 16'h1234);
        rchk(8'h0C, 16'hFFFF);
        wr(8'h6C, 16'h003F);
        repeat (2) @(posedge aclk);
        `CHK(mix, 2'h3)
        rchk(8'h00, 16'hC000);
        f0 = fcnt;
        run <= 1'b1;
        wait (fcnt == f0 + 5);
        repeat (20) @(posedge aclk);
        `CHK(runs, 4'h0)
        rchk(8'h00, 16'hC00C);
        wait (fcnt == f0 + 7);
        repeat (20) @(posedge aclk);
        `CHK(runs, 4'hF)
        rchk(8'h00, 16'hC00F);
        wr(8'h0C, 16'h1234);
        rchk(8'h0C, 16'h1234);
        for (int i = 0; i < 2; i++) begin
            wr(8'h70, 16'hBFE0);
            repeat (2) @(posedge aclk);
            rchk(8'h0C, 16'hFFFF);
            wr(8'h70, i ? 16'h3FE0 : 16'h7FE0);
            wait_up(n);
            `CHK(n > WAKE + CAL / 2, i == 0)
        end
        sleep <= 1'b1;
        repeat (10) @(posedge aclk);
        `CHK(pdn, 1'b1)
        sleep <= 1'b0;
        wait_up(n);
        `CHK(n > WAKE + CAL / 2, 1'b1)
        stop_test;
    end
    // whole sequence needs about 1500 cycles; allow over ten times that
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        stop_test;
    end
endmodule // tb
